/* File: rtl/rsp_pkg.sv */
// constants and types used by the serial slave port, which also sizes its fifo from them
// assumes: 7-bit address space, byte wide data, one system clock
package rsp_pkg;

	// address space
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam logic [6:0] RTC_FIRST = 7'h00;
	localparam logic [6:0] RTC_LAST = 7'h1f;
	localparam logic [6:0] RAM_FIRST = 7'h20;
	localparam logic [6:0] RAM_LAST = 7'h7f;

	// address byte layout
	localparam int DIR_POS = 7;
	localparam logic DIR_READ = 1'b0;

	// bit counting
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// reset values
	localparam logic CPOL_RST = 1'b0;
	localparam logic [6:0] PTR_RST = 7'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// write stream buffer
	localparam int FIFO_DEPTH = 32;
	localparam int WORD_W = ADDR_W + DATA_W;

	// transfer states
	typedef enum logic [1:0] {
		RSP_IDLE = 2'b00,
		RSP_ADDR = 2'b01,
		RSP_DATA = 2'b10
	} rsp_state_type;

endpackage : rsp_pkg

/* File: rtl/rsp_sync.sv */
// two flip-flop synchroniser for a bundle of asynchronous pins
// assumes: each bit is an independent level; no bus coherence is implied
`timescale 1ns/1ps
module rsp_sync #(
	parameter int WIDTH = 1
) (
	// system
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             en_in,
	// pins
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta  <= '0;
			q_out <= '0;
		end else if (en_in) begin
			meta  <= d_in;
			q_out <= meta;
		end
	end

endmodule : rsp_sync

/* File: rtl/rsp_fifo.sv */
// first-in first-out buffer with valid/ready on both sides
// assumes: DEPTH is a power of two; out_data_out is valid with out_valid_out
`timescale 1ns/1ps
module rsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// system
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             en_in,
	// fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wr_ptr;
	logic [PW:0]      rd_ptr;

	wire same_slot = wr_ptr[PW-1:0] == rd_ptr[PW-1:0];
	wire full      = same_slot && (wr_ptr[PW] != rd_ptr[PW]);
	wire push      = en_in && in_valid_in && !full;
	wire pop       = en_in && out_ready_in && (wr_ptr != rd_ptr);

	assign in_ready_out  = !full;
	assign out_valid_out = wr_ptr != rd_ptr;
	assign out_data_out  = mem[rd_ptr[PW-1:0]];

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr[PW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

endmodule : rsp_fifo

/* File: rtl/rsp_serial_port.sv */
// serial slave port of a real-time clock: spi or 3-wire, byte bursts
// assumes: all pins asynchronous; register store answers a read request
// with data valid in the cycle after rd_req_out; the shared 3-wire data
// line is resolved outside and its level arrives on sdi_in
//
// How it works
// RL1: strap high selects spi, strap low selects 3-wire single data line
// RL2: spi clock polarity is the clock level seen when chip enable rises
// RL3: one bit per serial clock period, bytes of eight, msb first in spi
// RL4: spi input taken on strobe edge, next output bit on shift edge
// RL5: master makes the serial clock, toggling only while bits move
// RL6: chip enable rising opens a transfer, falling closes it
// RL7: first byte after chip enable rises is the address byte
// RL8: address top bit zero means reads follow, one means writes follow
// RL9: reads drive addressed data out, writes take data from serial input
// RL10: pointer advances by one after every data byte until chip enable falls
// RL11: clock register pointer wraps from top back to bottom of that space
// RL12: ram pointer wraps from top back to the first ram location
// RL13: master keeps chip enable high and clocks on for further burst bytes
// RL14: 3-wire uses one joined data line with chip enable and clock
// RL15: 3-wire bytes move least significant bit first
// RL16: 3-wire samples on rising clock edge, drives on falling edge
// RL17: data output released when chip enable is low or during writes
`timescale 1ns/1ps
module rsp_serial_port #(
	parameter int FIFO_DEPTH = rsp_pkg::FIFO_DEPTH
) (
	// system
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	input  wire logic       clk_en_in,
	// serial pins
	input  wire logic       interface_select_pin_in,
	input  wire logic       ce_in,
	input  wire logic       sclk_in,
	input  wire logic       sdi_in,
	output logic            sdo_out,
	output logic            sdo_oe_out,
	// write stream to register store
	output logic            wr_valid_out,
	input  wire logic       wr_ready_in,
	output logic      [6:0] wr_addr_out,
	output logic      [7:0] wr_data_out,
	// read requests to register store
	output logic            rd_req_out,
	output logic      [6:0] rd_addr_out,
	input  wire logic [7:0] rd_data_in,
	// status
	output logic            busy_out,
	output logic            overflow_out
);

	// pointer step with wrap inside the space it started in
	function automatic logic [6:0] next_ptr(input logic [6:0] a);
		if (a == rsp_pkg::RTC_LAST) begin
			return rsp_pkg::RTC_FIRST;
		end else if (a == rsp_pkg::RAM_LAST) begin
			return rsp_pkg::RAM_FIRST;
		end
		return a + 7'h01;
	endfunction : next_ptr

	// reset release
	logic rst_meta_n;
	logic rst_q_n;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_n <= 1'b0;
			rst_q_n    <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_q_n    <= rst_meta_n;
		end
	end

	// pin synchronisers
	wire [3:0] pins_s;

	rsp_sync #(
		.WIDTH (4)
	) u_sync (
		.clk_in   (clk_sys_in),
		.rst_n_in (rst_q_n),
		.en_in    (clk_en_in),
		.d_in     ({interface_select_pin_in, ce_in, sclk_in, sdi_in}),
		.q_out    (pins_s)
	);

	wire mode_spi_s = pins_s[3];
	wire ce_s       = pins_s[2];
	wire sclk_s     = pins_s[1];
	wire sdi_s      = pins_s[0];

	// edge detection state
	logic ce_d;
	logic sclk_d;
	logic cpol;
	logic lsb_first;

	always_ff @(posedge clk_sys_in or negedge rst_q_n) begin
		if (!rst_q_n) begin
			ce_d   <= 1'b0;
			sclk_d <= 1'b0;
		end else if (clk_en_in) begin
			ce_d   <= ce_s;
			sclk_d <= sclk_s;
		end
	end

	wire ce_rise   = clk_en_in && ce_s && !ce_d; // see RL6
	wire sclk_edge = clk_en_in && ce_s && ce_d && (sclk_s != sclk_d);
	// strobe edge returns the clock to its idle level
	wire strobe    = sclk_edge && (sclk_s == cpol); // see RL4
	wire shift     = sclk_edge && (sclk_s != cpol); // see RL4

	// 3-wire acts as idle-high clock: rising samples, falling drives
	always_ff @(posedge clk_sys_in or negedge rst_q_n) begin
		if (!rst_q_n) begin
			cpol      <= rsp_pkg::CPOL_RST;
			lsb_first <= 1'b0;
		end else if (ce_rise) begin
			lsb_first <= !mode_spi_s; // see RL1 RL15
			cpol      <= mode_spi_s ? sclk_s : 1'b1; // see RL2 RL16
		end
	end

	// receive shifter
	logic       [7:0] rx;
	logic       [2:0] bit_cnt;
	rsp_pkg::rsp_state_type state;
	rsp_pkg::rsp_state_type next_state;
	logic             dir_read;
	logic       [6:0] ptr;

	// both modes read the same data input pin
	wire [7:0] next_rx   = lsb_first ? {sdi_s, rx[7:1]} : {rx[6:0], sdi_s}; // see RL3 RL15 RL14
	wire       byte_done = strobe && (bit_cnt == rsp_pkg::BIT_LAST); // see RL3
	wire       addr_done = byte_done && (state == rsp_pkg::RSP_ADDR);
	wire       data_done = byte_done && (state == rsp_pkg::RSP_DATA);
	wire       read_bit  = next_rx[rsp_pkg::DIR_POS] == rsp_pkg::DIR_READ; // see RL8
	wire [6:0] addr_fld  = next_rx[6:0];
	wire [6:0] ptr_step  = next_ptr(ptr); // see RL11 RL12

	always_ff @(posedge clk_sys_in or negedge rst_q_n) begin
		if (!rst_q_n) begin
			rx      <= rsp_pkg::BYTE_RST;
			bit_cnt <= rsp_pkg::BIT_FIRST;
		end else if (ce_rise) begin
			bit_cnt <= rsp_pkg::BIT_FIRST;
		end else if (strobe) begin
			rx      <= next_rx;
			bit_cnt <= bit_cnt + 3'h1; // see RL3
		end
	end

	// transfer sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			rsp_pkg::RSP_IDLE: begin
				if (ce_rise) begin
					next_state = rsp_pkg::RSP_ADDR; // see RL7
				end
			end
			rsp_pkg::RSP_ADDR: begin
				if (!ce_s) begin
					next_state = rsp_pkg::RSP_IDLE; // see RL6
				end else if (addr_done) begin
					next_state = rsp_pkg::RSP_DATA;
				end
			end
			rsp_pkg::RSP_DATA: begin
				if (!ce_s) begin
					next_state = rsp_pkg::RSP_IDLE; // see RL6
				end
			end
			default: begin
				next_state = rsp_pkg::RSP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_q_n) begin
		if (!rst_q_n) begin
			state    <= rsp_pkg::RSP_IDLE;
			busy_out <= 1'b0;
		end else if (clk_en_in) begin
			state    <= next_state;
			busy_out <= next_state != rsp_pkg::RSP_IDLE;
		end
	end

	// address pointer and direction
	always_ff @(posedge clk_sys_in or negedge rst_q_n) begin
		if (!rst_q_n) begin
			dir_read <= 1'b1;
			ptr      <= rsp_pkg::PTR_RST;
		end else if (addr_done) begin
			dir_read <= read_bit; // see RL8
			ptr      <= addr_fld;
		end else if (data_done) begin
			ptr      <= ptr_step; // see RL10
		end
	end

	// read fetch: request, then capture one cycle later
	logic       rd_wait;
	logic [7:0] tx;

	wire       next_rd_req = (addr_done && read_bit) || (data_done && dir_read);
	wire [6:0] next_rd_adr = addr_done ? addr_fld : ptr_step;
	wire [7:0] tx_src      = rd_wait ? rd_data_in : tx;
	wire       tx_bit      = lsb_first ? tx_src[0] : tx_src[7];
	wire [7:0] tx_shifted  = lsb_first ? {1'b0, tx_src[7:1]}
	                                   : {tx_src[6:0], 1'b0};
	wire       next_oe     = ce_s && ((addr_done && read_bit)
	                        || ((state == rsp_pkg::RSP_DATA) && dir_read)); // see RL17

	always_ff @(posedge clk_sys_in or negedge rst_q_n) begin
		if (!rst_q_n) begin
			rd_req_out  <= 1'b0;
			rd_addr_out <= rsp_pkg::PTR_RST;
			rd_wait     <= 1'b0;
		end else if (clk_en_in) begin
			rd_req_out  <= next_rd_req; // see RL9
			rd_wait     <= rd_req_out;
			if (next_rd_req) begin
				rd_addr_out <= next_rd_adr;
			end
		end
	end

	// transmit shifter
	always_ff @(posedge clk_sys_in or negedge rst_q_n) begin
		if (!rst_q_n) begin
			tx         <= rsp_pkg::BYTE_RST;
			sdo_out    <= 1'b0;
			sdo_oe_out <= 1'b0;
		end else if (clk_en_in) begin
			sdo_oe_out <= next_oe; // see RL17
			if (shift && sdo_oe_out) begin
				sdo_out <= tx_bit; // see RL4 RL16
				tx      <= tx_shifted;
			end else begin
				tx      <= tx_src;
			end
		end
	end

	// write path: one pending word ahead of the fifo
	logic        pend_valid;
	logic [14:0] pend_word;
	wire         fifo_ready;
	wire  [14:0] fifo_word;
	wire         fifo_valid;
	// output stage takes a word whenever it is empty or being taken
	wire         out_free = !wr_valid_out || wr_ready_in;
	wire         out_load = out_free && fifo_valid;

	wire wr_byte    = data_done && !dir_read; // see RL9
	wire pend_stuck = pend_valid && !fifo_ready;
	wire load_wr    = wr_byte && !pend_stuck;

	always_ff @(posedge clk_sys_in or negedge rst_q_n) begin
		if (!rst_q_n) begin
			pend_valid   <= 1'b0;
			pend_word    <= '0;
			overflow_out <= 1'b0;
		end else if (clk_en_in) begin
			pend_valid   <= load_wr || pend_stuck;
			// a lost byte sets the flag even on the opening edge
			overflow_out <= (wr_byte && pend_stuck)
			                || (overflow_out && !ce_rise);
			if (load_wr) begin
				pend_word <= {ptr, next_rx};
			end
		end
	end

	rsp_fifo #(
		.WIDTH (rsp_pkg::WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_sys_in),
		.rst_n_in      (rst_q_n),
		.en_in         (clk_en_in),
		.in_valid_in   (pend_valid),
		.in_ready_out  (fifo_ready),
		.in_data_in    (pend_word),
		.out_valid_out (fifo_valid),
		.out_ready_in  (out_free),
		.out_data_out  (fifo_word)
	);

	// registered write stream outputs, word held until taken
	always_ff @(posedge clk_sys_in or negedge rst_q_n) begin
		if (!rst_q_n) begin
			wr_valid_out <= 1'b0;
			wr_addr_out  <= rsp_pkg::PTR_RST;
			wr_data_out  <= rsp_pkg::BYTE_RST;
		end else if (clk_en_in) begin
			if (out_free) begin
				wr_valid_out <= fifo_valid;
			end
			if (out_load) begin
				wr_addr_out <= fifo_word[14:8];
				wr_data_out <= fifo_word[7:0];
			end
		end
	end

	// checks
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_q_n);

	sequence s_addr_read;
		addr_done && read_bit;
	endsequence

	sequence s_wr_byte;
		wr_byte && !pend_stuck;
	endsequence

	sequence s_open;
		ce_rise;
	endsequence

	a_mode_pick: assert property (s_open |=> lsb_first == !$past(mode_spi_s)) // see RL1 RL15
		else $error("bit order does not follow strap");
	a_polarity_take: assert property ( // see RL2
		(s_open and mode_spi_s) |=> cpol == $past(sclk_s))
		else $error("spi polarity not taken at chip enable");
	a_three_wire_edge: assert property ( // see RL16
		(s_open and !mode_spi_s) |=> cpol)
		else $error("3-wire not sampling on rising edge");
	a_addr_first: assert property (s_open |=> state == rsp_pkg::RSP_ADDR && bit_cnt == 3'h0) // see RL7
		else $error("transfer did not open on address byte");
	a_bit_order: assert property (strobe |=> (lsb_first ? rx[7] : rx[0]) == $past(sdi_s)) // see RL3 RL15
		else $error("bit entered at wrong end");
	a_dir_select: assert property (addr_done |=> dir_read == ($past(next_rx[7]) == 1'b0)) // see RL8
		else $error("direction bit misread");
	a_read_fetch: assert property (s_addr_read |=> rd_req_out && rd_addr_out == $past(next_rx[6:0])) // see RL9
		else $error("read not fetched from address");
	a_wr_push: assert property (s_wr_byte |=> pend_valid && pend_word == {$past(ptr), $past(next_rx)}) // see RL9
		else $error("write byte not queued");
	a_ptr_step: assert property (data_done && ptr != 7'h1f && ptr != 7'h7f |=> ptr == $past(ptr) + 7'h01) // see RL10
		else $error("pointer did not step by one");
	a_wrap_rtc: assert property (data_done && ptr == 7'h1f |=> ptr == 7'h00) // see RL11
		else $error("clock space did not wrap");
	a_wrap_ram: assert property (data_done && ptr == 7'h7f |=> ptr == 7'h20) // see RL12
		else $error("ram space did not wrap");
	a_shift_edge: assert property (sdo_oe_out && $changed(sdo_out) |-> $past(shift)) // see RL4 RL16
		else $error("output changed off the shift edge");
	a_oe_closed: assert property (!ce_s |=> ##1 !sdo_oe_out) // see RL17 RL6
		else $error("output driven without chip enable");
	a_no_drive_wr: assert property (state == rsp_pkg::RSP_DATA && !dir_read |-> !sdo_oe_out) // see RL17
		else $error("output driven during write");
	a_out_hold: assert property ( // see RL9
		wr_valid_out && !wr_ready_in
		|=> wr_valid_out && $stable(wr_addr_out)
			&& $stable(wr_data_out))
		else $error("write word changed before taken");

endmodule : rsp_serial_port

/* File: tb/rsp_host_model.sv */
// serial bus master model: frames transfers and moves bits on the link
// assumes: system clock drives its timing; sclk half period of 4 clocks
`timescale 1ns/1ps
module rsp_host_model (
	// timing and slave data return
	input  wire logic clk_in,
	input  wire logic miso_in,
	// link pins
	output logic      select_out,
	output logic      ce_out,
	output logic      sclk_out,
	output logic      mosi_out,
	output logic      mosi_oe_out
);
	logic spi;
	logic cpol;

	initial begin
		select_out = 1'b1;
		ce_out = 1'b0;
		sclk_out = 1'b0;
		mosi_out = 1'b0;
		mosi_oe_out = 1'b0;
		spi = 1'b1;
		cpol = 1'b0;
	end

	task automatic start(input logic use_spi, input logic pol);
		spi = use_spi;
		cpol = use_spi ? pol : 1'b0;
		select_out <= use_spi;
		sclk_out <= cpol;
		repeat (6) @(posedge clk_in);
		ce_out <= 1'b1;
		repeat (6) @(posedge clk_in);
	endtask : start

	// burst bytes keep chip enable high between calls
	task automatic xbyte(input logic [7:0] tx, input logic drive,
		input int nbits, output logic [7:0] rx);
		int idx;
		rx = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			idx = spi ? 7 - i : i;
			if (spi)
				sclk_out <= ~cpol;
			mosi_oe_out <= drive;
			mosi_out <= tx[idx];
			repeat (4) @(posedge clk_in);
			sclk_out <= spi ? cpol : 1'b1;
			repeat (2) @(posedge clk_in);
			rx[idx] = miso_in;
			repeat (2) @(posedge clk_in);
			if (!spi)
				sclk_out <= 1'b0;
		end
	endtask : xbyte

	task automatic stop();
		repeat (4) @(posedge clk_in);
		mosi_oe_out <= 1'b0;
		ce_out <= 1'b0;
		repeat (8) @(posedge clk_in);
	endtask : stop
endmodule : rsp_host_model

/* File: tb/tb_rtc_serial_slave_port.sv */
// self-checking bench of the serial slave port with a host model
// assumes: register store modelled here, read data one cycle after request
`timescale 1ns/1ps
module tb_rtc_serial_slave_port;
	logic       clk, clk_en, rst_n, strap, ce, sclk, mosi, mosi_oe;
	logic       sdo, sdo_oe, wr_valid, wr_ready, rd_req, busy, ovf;
	logic [6:0] wr_addr, rd_addr;
	logic [7:0] wr_data, rd_data;
	logic       idle_tog, hold_ready, in_write, r_spi, r_pol, r_wr;
	logic [7:0] mem [128];
	logic [14:0] exp_q [$];
	int         seed = 62584;
	int         miscompares = 0;
	int         total_checks = 0;
	wire        sdi = (!strap && sdo_oe) ? sdo : (mosi_oe ? mosi : idle_tog);
	wire        miso = sdo_oe ? sdo : idle_tog;

	rsp_serial_port i_rsp_serial_port (
		.clk_sys_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
		.interface_select_pin_in(strap), .ce_in(ce), .sclk_in(sclk),
		.sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
		.wr_valid_out(wr_valid), .wr_ready_in(wr_ready),
		.wr_addr_out(wr_addr), .wr_data_out(wr_data),
		.rd_req_out(rd_req), .rd_addr_out(rd_addr), .rd_data_in(rd_data),
		.busy_out(busy), .overflow_out(ovf)
	);

	rsp_host_model i_rsp_host_model (
		.clk_in(clk), .miso_in(miso), .select_out(strap), .ce_out(ce),
		.sclk_out(sclk), .mosi_out(mosi), .mosi_oe_out(mosi_oe)
	);

	task automatic chk_data(input logic [14:0] got, input logic [14:0] exp,
		input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_data

	task automatic chk_flag(input logic got, input logic exp, input string what);
		chk_data({14'h0, got}, {14'h0, exp}, what);
	endtask : chk_flag

	function automatic logic [6:0] next_ptr(input logic [6:0] a);
		if (a == 7'h1f)
			return 7'h00;
		if (a == 7'h7f)
			return 7'h20;
		return a + 7'h01;
	endfunction : next_ptr

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// one framed transfer; cut > 0 appends a partial byte before closing
	task automatic transfer(input logic spi, input logic pol, input logic wr,
		input logic [6:0] addr, input int n, input int cut);
		logic [7:0] rx;
		logic [7:0] tx;
		logic [6:0] ptr;
		ptr = addr;
		i_rsp_host_model.start(spi, pol);
		chk_flag(busy, 1'b1, "busy open");
		chk_flag(ovf, 1'b0, "overflow cleared");
		in_write <= wr;
		i_rsp_host_model.xbyte({wr, addr}, 1'b1, 8, rx);
		for (int i = 0; i < n; i++) begin
			tx = 8'($random(seed));
			i_rsp_host_model.xbyte(tx, wr | spi, 8, rx);
			if (wr)
				exp_q.push_back({ptr, tx});
			else
				chk_data({7'h0, rx}, {7'h0, mem[ptr]}, "read");
			ptr = next_ptr(ptr);
		end
		if (cut > 0)
			i_rsp_host_model.xbyte(8'hff, 1'b1, cut, rx);
		i_rsp_host_model.stop();
		in_write <= 1'b0;
		chk_flag(sdo_oe, 1'b0, "released");
		chk_flag(busy, 1'b0, "busy closed");
	endtask : transfer

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			idle_tog <= 1'b0;
			wr_ready <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			idle_tog <= ~idle_tog;
			wr_ready <= !hold_ready && 1'($random(seed));
			rd_data <= rd_req ? mem[rd_addr] : 8'($random(seed));
		end
		// a frozen port takes nothing, so no word is consumed then
		if (clk_en && wr_valid === 1'b1 && wr_ready === 1'b1) begin
			if (exp_q.size() == 0)
				chk_flag(wr_valid, 1'b0, "extra word");
			else
				chk_data({wr_addr, wr_data}, exp_q.pop_front(), "word");
		end
		if (in_write)
			chk_flag(sdo_oe, 1'b0, "drive in write");
	end

	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		$display("mismatch at %0t: watchdog expired", $time);
		test_done();
	end

	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		hold_ready = 1'b0;
		in_write = 1'b0;
		for (int i = 0; i < 128; i++)
			mem[i] = 8'($random(seed));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		transfer(1'b1, 1'b1, 1'b0, 7'h1e, 4, 0);
		transfer(1'b0, 1'b0, 1'b1, 7'h7e, 4, 0);
		transfer(1'b1, 1'b0, 1'b1, 7'h1f, 3, 0);
		transfer(1'b0, 1'b0, 1'b0, 7'h7f, 3, 0);
		for (int k = 0; k < 24; k++) begin
			r_spi = 1'($random(seed));
			r_pol = 1'($random(seed));
			r_wr = 1'($random(seed));
			transfer(r_spi, r_pol, r_wr, 7'($random(seed)),
				1 + ($unsigned($random(seed)) % 4), 0);
		end
		transfer(1'b1, 1'b1, 1'b1, 7'h10, 1, 5);
		transfer(1'b0, 1'b0, 1'b1, 7'h40, 1, 3);
		hold_ready <= 1'b1;
		// stalled store holds 34 words: output stage, fifo, pending slot
		transfer(1'b1, 1'b0, 1'b1, 7'h20, 35, 0);
		void'(exp_q.pop_back());
		chk_flag(ovf, 1'b1, "overflow set");
		clk_en <= 1'b0;
		hold_ready <= 1'b0;
		repeat (20) @(posedge clk);
		chk_flag(wr_valid, 1'b1, "frozen word held");
		clk_en <= 1'b1;
		for (int w = 0; w < 3000 && exp_q.size() > 0; w++)
			@(posedge clk);
		chk_flag(exp_q.size() == 0, 1'b1, "drained");
		transfer(1'b1, 1'b1, 1'b0, 7'h00, 1, 0);
		test_done();
	end
endmodule : tb_rtc_serial_slave_port
